// ==== design/eesac_pkg.sv ====
// constants, types and access-permission function for the eeprom shadow access controller
package eesac_pkg;

  // ****************************************************************
  // direct register byte addresses
  // ****************************************************************
  localparam logic [5:0] REG_EXT_ADDR_HI = 6'h02;
  localparam logic [5:0] REG_EXT_ADDR = 6'h03;
  localparam logic [5:0] REG_EXT_DATA_B3 = 6'h04;
  localparam logic [5:0] REG_EXT_DATA_B2 = 6'h05;
  localparam logic [5:0] REG_EXT_DATA_B1 = 6'h06;
  localparam logic [5:0] REG_EXT_DATA_B0 = 6'h07;
  localparam logic [5:0] REG_EXT_CTRL = 6'h08;
  localparam logic [5:0] REG_EXT_STAT = 6'h09;
  localparam logic [5:0] REG_WARN = 6'h0a;
  localparam logic [5:0] REG_KEY = 6'h3c;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int GO_BIT = 7;
  localparam int DONE_BIT = 0;
  localparam int WARN_BIT = 0;
  localparam int LOCK_LSB = 0;
  localparam int USER_SEL_BIT = 4;
  localparam int PROT_BYP_BIT = 5;
  localparam int KEY_BYP_BIT = 6;
  localparam int DATA_BITS = 24;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [3:0] RST_LOCK = 4'h0;
  localparam logic [DATA_BITS-1:0] RST_SHADOW = 24'h00_0000;

  // ****************************************************************
  // extended address map and protection codes
  // ****************************************************************
  localparam logic [1:0] EXT_NV_PAGE = 2'b00;
  localparam logic [1:0] EXT_SHADOW_PAGE = 2'b01;
  localparam logic [7:0] EXT_SHADOW_OFS = 8'h40;
  localparam logic [5:0] WORD_USER2 = 6'h17;
  localparam logic [5:0] WORD_USER1 = 6'h1f;
  localparam logic [5:0] CFG_WORD = 6'h3e;
  localparam logic [5:0] LAST_WORD = 6'h3f;
  localparam logic [3:0] LOCK_NV = 4'hc;
  localparam logic [3:0] LOCK_ALL = 4'h3;
  localparam logic [4:0][7:0] KEY_SEQ = {8'h77, 8'h1f, 8'h81, 8'h27, 8'h00};
  localparam logic [2:0] KEY_LAST = 3'h4;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int NV_WRITE_MS = 24;
  localparam int CLK_MHZ = 125;
  localparam int NV_WRITE_CYC_DEF = NV_WRITE_MS * 1000 * CLK_MHZ;
  localparam int TMR_W = 22;

  typedef enum logic [2:0] {
    ST_BOOT_RD = 3'b000,
    ST_BOOT_WT = 3'b001,
    ST_IDLE = 3'b010,
    ST_CHK = 3'b011,
    ST_NV_WT = 3'b100
  } eesac_state_t;

  // shadow words follow the eeprom lock except that code c leaves them free
  function automatic logic eesac_permit(input logic [5:0] word, input logic shadow,
                                        input logic unlocked, input logic [3:0] lock,
                                        input logic user_sel, input logic prot_byp,
                                        input logic key_byp);
    logic locked;
    logic user;
    locked = (lock == LOCK_ALL) || (!shadow && (lock == LOCK_NV));
    user = (word == WORD_USER2) || (user_sel && (word == WORD_USER1));
    if (!locked) begin
      return unlocked || (user && key_byp);
    end
    return user && prot_byp && (unlocked || key_byp);
  endfunction : eesac_permit

endpackage : eesac_pkg

// ==== design/eesac_shd_if.sv ====
// link between the access controller and its shadow memory
`timescale 1ns/10ps
interface eesac_shd_if;
  logic wr_en;
  logic [5:0] wr_addr;
  logic [23:0] wr_data;
  logic [5:0] rd_addr;
  logic [31:0] rd_data;
  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : eesac_shd_if

// ==== design/eesac_shadow.sv ====
// volatile shadow memory, data bits only
`timescale 1ns/10ps
module eesac_shadow
  import eesac_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  eesac_shd_if.mem sh
);

  typedef struct packed {
    logic [63:0][DATA_BITS-1:0] mem;
    logic [31:0] rd;
  } eesac_shd_st_t;

  eesac_shd_st_t r;
  eesac_shd_st_t n;

  // check bits and unused bits have no storage and read as zero
  always_comb begin
    n = r;
    if (sh.wr_en) begin
      n.mem[sh.wr_addr] = sh.wr_data;
    end
    n.rd = {8'h00, r.mem[sh.rd_addr]};
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign sh.rd_data = r.rd;

endmodule : eesac_shadow

// ==== design/eesac_ctrl.sv ====
// eeprom and shadow access controller: unlock, locks, extended write engine, boot copy
`timescale 1ns/10ps
// Function
// - at power-up copy every eeprom word into shadow memory
// - shadow-address extended write changes shadow only, never the eeprom
// - shadow word sits at extended address eeprom word plus 0x40, same layout
// - shadow memory keeps no error-correction check bits
// - shadow writes obey the same protection except under lock code c; reads need no unlock
// - five key bytes 00 27 81 1f 77 to register 0x3c grant writes
// - granted write access stays until next power-on reset
// - lock code c blocks eeprom writes, shadow writes still allowed
// - lock code 3 blocks eeprom and shadow writes alike
// - a stored lock code can never be returned to unlocked
// - user-word select, lock bypass, key bypass default zero, normal rules then
// - unlocked part: key bypass frees word 0x17, and 0x1f with select
// - locked part: only bypassed user words writable, after key or key bypass
// - host loads 8-bit target extended address before a write
// - writing go bit starts store of data at loaded address
// - completion sets the done bit; eeprom write waits up to 24 ms
// - shadow write completes in one clock cycle after the request
// - refused or aborted write sets done and the access warning
module eesac_ctrl
  import eesac_pkg::*;
#(
  parameter int NV_WRITE_CYC = NV_WRITE_CYC_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic nvm_req,
  output logic nvm_we,
  output logic [5:0] nvm_addr,
  output logic [31:0] nvm_wdata,
  input wire logic [31:0] nvm_rdata,
  input wire logic nvm_ack,
  input wire logic nvm_fail,
  input wire logic [5:0] cfg_rd_addr,
  output logic [31:0] cfg_rd_data,
  output logic boot_done
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    eesac_state_t st;
    logic [5:0] idx;
    logic [7:0] ext_addr;
    logic [31:0] ext_data;
    logic pend;
    logic done;
    logic warn;
    logic [2:0] key_step;
    logic unlocked;
    logic [3:0] lock;
    logic user_sel;
    logic prot_byp;
    logic key_byp;
    logic nv_req;
    logic nv_we;
    logic [5:0] nv_addr;
    logic [31:0] nv_wdata;
    logic [TMR_W-1:0] tmr;
    logic [7:0] rdata;
    logic boot_done;
  } eesac_ctl_st_t;

  eesac_ctl_st_t r;
  eesac_ctl_st_t n;
  eesac_shd_if sh ();
  logic busy, tgt_nv, tgt_shadow, perm_ok;

  eesac_shadow u_shadow (
    .sys_clk (sys_clk),
    .rst_n (rst_n),
    .sh (sh)
  );

  assign busy = r.pend || (r.st == ST_CHK) || (r.st == ST_NV_WT) || !r.boot_done;
  assign tgt_nv = r.ext_addr[7:6] == EXT_NV_PAGE;
  assign tgt_shadow = r.ext_addr[7:6] == EXT_SHADOW_PAGE;
  assign perm_ok = eesac_permit(r.ext_addr[5:0], tgt_shadow, r.unlocked, r.lock,
                                r.user_sel, r.prot_byp, r.key_byp);

  // ****************************************************************
  // shadow port: boot copy and single-cycle shadow writes
  // ****************************************************************
  always_comb begin
    sh.rd_addr = cfg_rd_addr;
    sh.wr_en = 1'b0;
    sh.wr_addr = r.idx;
    sh.wr_data = nvm_rdata[DATA_BITS-1:0];
    if ((r.st == ST_BOOT_WT) && nvm_ack) begin
      sh.wr_en = 1'b1;
    end else if ((r.st == ST_CHK) && tgt_shadow && perm_ok) begin
      sh.wr_en = 1'b1;
      sh.wr_addr = r.ext_addr[5:0];
      sh.wr_data = r.ext_data[DATA_BITS-1:0];
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    n = r;
    // direct register writes
    if (reg_wr_en) begin
      unique case (reg_addr)
        REG_EXT_ADDR: n.ext_addr = reg_wdata;
        REG_EXT_DATA_B3: n.ext_data[31:24] = reg_wdata;
        REG_EXT_DATA_B2: n.ext_data[23:16] = reg_wdata;
        REG_EXT_DATA_B1: n.ext_data[15:8] = reg_wdata;
        REG_EXT_DATA_B0: n.ext_data[7:0] = reg_wdata;
        REG_EXT_CTRL: begin
          // a go while busy is dropped; the running transfer is never disturbed
          if (reg_wdata[GO_BIT] && !busy) begin
            n.pend = 1'b1;
            n.done = 1'b0;
          end
        end
        REG_WARN: begin
          if (reg_wdata[WARN_BIT]) begin
            n.warn = 1'b0;
          end
        end
        REG_KEY: begin
          if (!r.unlocked) begin
            if (reg_wdata == KEY_SEQ[r.key_step]) begin
              if (r.key_step == KEY_LAST) begin
                n.unlocked = 1'b1;
                n.key_step = 3'h0;
              end else begin
                n.key_step = r.key_step + 3'h1;
              end
            end else if (reg_wdata == KEY_SEQ[0]) begin
              n.key_step = 3'h1;
            end else begin
              n.key_step = 3'h0;
            end
          end
        end
        default: begin
        end
      endcase
    end
    // direct register reads, answered one cycle later; unmapped reads zero
    if (reg_rd_en) begin
      unique case (reg_addr)
        REG_EXT_ADDR: n.rdata = r.ext_addr;
        REG_EXT_DATA_B3: n.rdata = r.ext_data[31:24];
        REG_EXT_DATA_B2: n.rdata = r.ext_data[23:16];
        REG_EXT_DATA_B1: n.rdata = r.ext_data[15:8];
        REG_EXT_DATA_B0: n.rdata = r.ext_data[7:0];
        REG_EXT_CTRL: n.rdata = {busy, 7'h00};
        REG_EXT_STAT: n.rdata = {7'h00, r.done};
        REG_WARN: n.rdata = {7'h00, r.warn};
        default: n.rdata = RST_BYTE;
      endcase
    end
    // transfer engine; set of done or warning comes last so it wins a clear
    unique case (r.st)
      ST_BOOT_RD: begin
        n.nv_req = 1'b1;
        n.nv_we = 1'b0;
        n.nv_addr = r.idx;
        n.st = ST_BOOT_WT;
      end
      ST_BOOT_WT: begin
        if (nvm_ack) begin
          n.nv_req = 1'b0;
          if (r.idx == CFG_WORD) begin
            n.lock = nvm_rdata[LOCK_LSB +: 4];
            n.user_sel = nvm_rdata[USER_SEL_BIT];
            n.prot_byp = nvm_rdata[PROT_BYP_BIT];
            n.key_byp = nvm_rdata[KEY_BYP_BIT];
          end
          if (r.idx == LAST_WORD) begin
            n.boot_done = 1'b1;
            n.st = ST_IDLE;
          end else begin
            n.idx = r.idx + 6'h01;
            n.st = ST_BOOT_RD;
          end
        end
      end
      ST_IDLE: begin
        if (r.pend) begin
          n.pend = 1'b0;
          n.st = ST_CHK;
        end
      end
      ST_CHK: begin
        if (!(tgt_nv || tgt_shadow) || !perm_ok) begin
          n.done = 1'b1;
          n.warn = 1'b1;
          n.st = ST_IDLE;
        end else if (tgt_shadow) begin
          n.done = 1'b1;
          n.st = ST_IDLE;
        end else begin
          n.nv_req = 1'b1;
          n.nv_we = 1'b1;
          n.nv_addr = r.ext_addr[5:0];
          n.nv_wdata = r.ext_data;
          n.tmr = '0;
          n.st = ST_NV_WT;
        end
      end
      ST_NV_WT: begin
        n.tmr = r.tmr + 1'b1;
        if (nvm_ack) begin
          n.nv_req = 1'b0;
          n.done = 1'b1;
          if (nvm_fail) begin
            n.warn = 1'b1;
          end else if (r.nv_addr == CFG_WORD) begin
            // a locked part never reaches here for this word, so locks only tighten
            n.lock = r.nv_wdata[LOCK_LSB +: 4];
            n.user_sel = r.nv_wdata[USER_SEL_BIT];
            n.prot_byp = r.nv_wdata[PROT_BYP_BIT];
            n.key_byp = r.nv_wdata[KEY_BYP_BIT];
          end
          n.st = ST_IDLE;
        end else if (r.tmr == TMR_W'(NV_WRITE_CYC - 1)) begin
          n.nv_req = 1'b0;
          n.done = 1'b1;
          n.warn = 1'b1;
          n.st = ST_IDLE;
        end
      end
      default: n.st = ST_IDLE;
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.st <= ST_BOOT_RD;
      r.lock <= RST_LOCK;
      r.ext_data <= RST_WORD;
    end else begin
      r <= n;
    end
  end

  assign reg_rdata = r.rdata;
  assign nvm_req = r.nv_req;
  assign nvm_we = r.nv_we;
  assign nvm_addr = r.nv_addr;
  assign nvm_wdata = r.nv_wdata;
  assign cfg_rd_data = sh.rd_data;
  assign boot_done = r.boot_done;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_boot_copy;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(r.boot_done) |-> ($past(r.idx) == LAST_WORD) && $past(nvm_ack);
  endproperty
  a_boot_copy: assert property (p_boot_copy) else $error("boot ended early");
  property p_shadow_one_cycle;
    @(posedge sys_clk) disable iff (!rst_n)
      (r.st == ST_CHK && tgt_shadow && perm_ok) |-> sh.wr_en ##1 (r.done && !r.nv_req);
  endproperty
  a_shadow_one_cycle: assert property (p_shadow_one_cycle) else $error("shadow slow");
  property p_unused_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      cfg_rd_data[31:DATA_BITS] == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits set");
  property p_key_grant;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(r.unlocked) |-> $past(reg_wr_en && reg_addr == REG_KEY && reg_wdata == 8'h77);
  endproperty
  a_key_grant: assert property (p_key_grant) else $error("unlock without key");
  property p_unlock_sticky;
    @(posedge sys_clk) disable iff (!rst_n)
      r.unlocked |=> r.unlocked;
  endproperty
  a_unlock_sticky: assert property (p_unlock_sticky) else $error("unlock lost");
  property p_lock_perm;
    @(posedge sys_clk) disable iff (!rst_n)
      (r.boot_done && (r.lock == LOCK_NV || r.lock == LOCK_ALL)) |=> $stable(r.lock);
  endproperty
  a_lock_perm: assert property (p_lock_perm) else $error("lock changed");
  property p_nv_locked;
    @(posedge sys_clk) disable iff (!rst_n)
      (r.st == ST_CHK && tgt_nv && (r.lock == LOCK_NV || r.lock == LOCK_ALL) && !r.prot_byp)
      |=> !r.nv_req && r.warn && r.done;
  endproperty
  a_nv_locked: assert property (p_nv_locked) else $error("locked eeprom written");
  property p_all_locked;
    @(posedge sys_clk) disable iff (!rst_n)
      (r.st == ST_CHK && tgt_shadow && r.lock == LOCK_ALL && !r.prot_byp)
      |-> !sh.wr_en ##1 r.warn;
  endproperty
  a_all_locked: assert property (p_all_locked) else $error("locked shadow written");
  property p_go_start;
    @(posedge sys_clk) disable iff (!rst_n)
      (reg_wr_en && reg_addr == REG_EXT_CTRL && reg_wdata[GO_BIT] && !busy)
      |=> !r.done ##1 (r.st == ST_CHK);
  endproperty
  a_go_start: assert property (p_go_start) else $error("go not started");
  property p_nv_bound;
    @(posedge sys_clk) disable iff (!rst_n)
      (r.st == ST_NV_WT) |-> (r.tmr < TMR_W'(NV_WRITE_CYC));
  endproperty
  a_nv_bound: assert property (p_nv_bound) else $error("write wait overran");
  property p_fail_warn;
    @(posedge sys_clk) disable iff (!rst_n)
      (r.st == ST_NV_WT && nvm_ack && nvm_fail) |=> r.warn && r.done && (r.st == ST_IDLE);
  endproperty
  a_fail_warn: assert property (p_fail_warn) else $error("abort not flagged");

  c_unlock: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(r.unlocked));
  c_shadow_wr: cover property (@(posedge sys_clk) disable iff (!rst_n)
    r.st == ST_CHK && tgt_shadow && perm_ok);
  c_nv_done: cover property (@(posedge sys_clk) disable iff (!rst_n)
    r.st == ST_NV_WT && nvm_ack && !nvm_fail);
  c_denied: cover property (@(posedge sys_clk) disable iff (!rst_n)
    r.st == ST_CHK && !perm_ok);

endmodule : eesac_ctrl

// ==== tb/eesac_nvm_model.sv ====
// behavioural eeprom array answering the controller's word port
`timescale 1ns/10ps
module eesac_nvm_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic nvm_req,
  input wire logic nvm_we,
  input wire logic [5:0] nvm_addr,
  input wire logic [31:0] nvm_wdata,
  output logic [31:0] nvm_rdata,
  output logic nvm_ack,
  output logic nvm_fail,
  input wire logic [3:0] ack_dly,
  input wire logic fail_en,
  input wire logic hang_en
);
  // not reset: contents survive power cycles, the bench presets them
  logic [31:0] mem [64];
  logic [3:0] cnt;

  // ************************************************************
  // request service
  // ************************************************************
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      nvm_ack <= 1'b0;
      nvm_fail <= 1'b0;
      cnt <= 4'h0;
      nvm_rdata <= 32'h3c3c_a5a5;
    end else begin
      nvm_ack <= 1'b0;
      nvm_fail <= 1'b0;
      // read data is only valid in the ack cycle, so it toggles otherwise
      nvm_rdata <= ~nvm_rdata;
      if (nvm_req && !nvm_ack && !hang_en) begin
        if (cnt >= ack_dly) begin
          nvm_ack <= 1'b1;
          cnt <= 4'h0;
          nvm_fail <= nvm_we && fail_en;
          if (!nvm_we) begin
            nvm_rdata <= mem[nvm_addr];
          end else if (!fail_en) begin
            mem[nvm_addr] <= nvm_wdata;
          end
        end else begin
          cnt <= cnt + 4'h1;
        end
      end else begin
        cnt <= 4'h0;
      end
    end
  end
endmodule : eesac_nvm_model

// ==== tb/testbench.sv ====
// self-checking bench for the eeprom shadow access controller
`timescale 1ns/10ps
module testbench
  import eesac_pkg::*;
;
  logic sys_clk, rst_n, reg_wr_en, reg_rd_en, nvm_req, nvm_we, nvm_ack, nvm_fail, boot_done;
  logic fail_en, hang_en;
  logic [5:0] reg_addr, cfg_rd_addr, nvm_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [31:0] nvm_wdata, nvm_rdata, cfg_rd_data;
  logic [3:0] ack_dly;
  logic [23:0] shd [64];
  logic [5:0] wl [3] = '{6'h17, 6'h1f, CFG_WORD};
  int failures, n_tests, cyc;

  eesac_ctrl #(.NV_WRITE_CYC(50)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .nvm_req(nvm_req), .nvm_we(nvm_we),
    .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata), .nvm_ack(nvm_ack),
    .nvm_fail(nvm_fail), .cfg_rd_addr(cfg_rd_addr), .cfg_rd_data(cfg_rd_data),
    .boot_done(boot_done));

  eesac_nvm_model nvm (.sys_clk(sys_clk), .rst_n(rst_n), .nvm_req(nvm_req), .nvm_we(nvm_we),
    .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata), .nvm_ack(nvm_ack),
    .nvm_fail(nvm_fail), .ack_dly(ack_dly), .fail_en(fail_en), .hang_en(hang_en));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ************************************************************
  // compare, bus and closing tasks
  // ************************************************************
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  // a spare cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask : rd

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 3000 && boot_done !== 1'b1; i++) @(posedge sys_clk);
    chk_bit("boot_done", 1'b1, boot_done);
    for (int i = 0; i < 64; i++) shd[i] = nvm.mem[i][23:0];
  endtask : do_reset

  task automatic cfg_chk(input logic [5:0] w);
    cfg_rd_addr <= w;
    repeat (2) @(posedge sys_clk);
    chk_word("shadow word", {8'h00, shd[w]}, cfg_rd_data);
  endtask : cfg_chk

  task automatic key(input logic bad);
    for (int i = 0; i < 5; i++) begin
      if (bad && i == 3) wr(REG_KEY, 8'h55);
      wr(REG_KEY, KEY_SEQ[i]);
    end
  endtask : key

  // fast: refused, invalid and shadow writes finish at the third edge after go
  task automatic ext_wr(input logic [7:0] a, input logic [31:0] d, input logic warn,
                        input logic fast);
    logic [7:0] s;
    int n;
    wr(REG_EXT_ADDR, a);
    for (int i = 0; i < 4; i++) wr(6'(REG_EXT_DATA_B3 + i), d[31-8*i -: 8]);
    wr(REG_EXT_CTRL, 8'h80);
    @(posedge sys_clk);
    rd(REG_EXT_STAT, s);
    n = 1;
    while (s[DONE_BIT] !== 1'b1 && n < 200) begin
      rd(REG_EXT_STAT, s);
      n++;
    end
    chk_bit("write_complete", 1'b1, s[DONE_BIT]);
    if (fast) chk_word("status polls", 32'h1, 32'(n));
    rd(REG_WARN, s);
    chk_bit("ext_access_warning", warn, s[WARN_BIT]);
    wr(REG_WARN, 8'h01);
  endtask : ext_wr

  function automatic logic may(logic [31:0] c, logic [5:0] w, logic sh, logic k);
    logic lk;
    logic us;
    lk = (c[3:0] == 4'h3) || (!sh && c[3:0] == 4'hc);
    us = (w == 6'h17) || (c[USER_SEL_BIT] && w == 6'h1f);
    return lk ? (us && c[PROT_BYP_BIT] && (k || c[KEY_BYP_BIT])) : (k || (us && c[KEY_BYP_BIT]));
  endfunction : may

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      failures++;
      results;
    end
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    logic [31:0] cfgw, d, old;
    logic [2:0] b;
    logic ok;
    logic sh;
    logic [5:0] w;
    logic [7:0] s;
    rst_n = 1'b0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    cfg_rd_addr = 6'h00;
    fail_en = 1'b0;
    hang_en = 1'b0;
    failures = 0;
    n_tests = 0;
    for (int i = 0; i < 64; i++) nvm.mem[i] = 32'hc500_0000 | 32'(i * 32'h0001_0203);
    // lock codes 0, c and 3 against every bypass combination, before and after the key
    for (int c = 0; c < 24; c++) begin
      b = 3'(c / 3);
      cfgw = 32'h0000_0000;
      cfgw[3:0] = (c % 3 == 0) ? 4'h0 : ((c % 3 == 1) ? LOCK_NV : LOCK_ALL);
      cfgw[USER_SEL_BIT] = b[0];
      cfgw[PROT_BYP_BIT] = b[1];
      cfgw[KEY_BYP_BIT] = b[2];
      nvm.mem[CFG_WORD] = cfgw;
      ack_dly <= 4'((c % 2) * 6);
      do_reset;
      cfg_chk(CFG_WORD);
      cfg_chk(6'h20);
      for (int k = 0; k < 2; k++) begin
        key(k == 0);
        for (int j = 0; j < 6; j++) begin
          w = wl[j/2];
          sh = 1'(j % 2);
          ok = may(cfgw, w, sh, 1'(k));
          // user-word data differs for every config, pass and word, so a wrongly allowed user-word write shows; the config word is rewritten with its own value
          d = (w == CFG_WORD) ? cfgw : (32'hffa4_0000 | 32'(c * 256 + k * 64 + w));
          old = nvm.mem[w];
          ext_wr({1'b0, sh, w}, d, !ok, sh || !ok);
          if (sh && ok) shd[w] = d[23:0];
          chk_word("eeprom word", (!sh && ok) ? d : old, nvm.mem[w]);
          if (sh) cfg_chk(w);
        end
      end
      $display("test lock config %0d finished", c);
    end
    nvm.mem[CFG_WORD] = 32'h0000_0000;
    ack_dly <= 4'h2;
    do_reset;
    key(1'b0);
    rd(REG_KEY, s);
    chk_word("key readback", 32'h0, {24'h0, s});
    rd(6'h3f, s);
    chk_word("unmapped readback", 32'h0, {24'h0, s});
    fail_en <= 1'b1;
    ext_wr(8'h10, 32'h0012_3456, 1'b1, 1'b0);
    fail_en <= 1'b0;
    hang_en <= 1'b1;
    ext_wr(8'h11, 32'h0065_4321, 1'b1, 1'b0);
    hang_en <= 1'b0;
    ext_wr(8'h80, 32'h0000_0001, 1'b1, 1'b1);
    rd(REG_EXT_ADDR, s);
    chk_word("ext_write_address readback", 32'h80, {24'h0, s});
    rd(REG_EXT_DATA_B0, s);
    chk_word("ext_write_data readback", 32'h01, {24'h0, s});
    rd(REG_EXT_CTRL, s);
    chk_word("ext_write_control busy", 32'h00, {24'h0, s});
    $display("test fault paths finished");
    results;
  end
endmodule : testbench
